// ### csd_map.vh
/*
 * Register map, field positions, reset values and encodings of the clock
 * select and divider block.
 * Assumes inclusion by bare name from the block's design file.
 */
`ifndef CSD_MAP_VH
`define CSD_MAP_VH

// ****************************************
// Register byte offsets
// ****************************************
`define CSD_OFS_SRCSEL 12'h000
`define CSD_OFS_DIVCTL 12'h004
`define CSD_OFS_TICKCSR 12'h008
`define CSD_OFS_PWRCTL 12'h00C
`define CSD_OFS_PERSEL 12'h010
`define CSD_OFS_STATUS 12'h014

// ****************************************
// Field positions
// ****************************************
`define CSD_SYS_SEL_LSB 0
`define CSD_SYS_SEL_MSB 2
`define CSD_TICK_SEL_LSB 3
`define CSD_TICK_SEL_MSB 5
`define CSD_TICK_SRC_BIT 2
`define CSD_DIV_SEL_LSB 0
`define CSD_DIV_SEL_MSB 3
`define CSD_DIV_EN_BIT 4
`define CSD_DIV_BYP_BIT 5
`define CSD_PD_REQ_BIT 0
`define CSD_PD_KEEP_BIT 1
`define CSD_XTL_LSB 2
`define CSD_XTL_MSB 3

// ****************************************
// Encodings and reset values
// ****************************************
`define CSD_SRC_EXT 2'h0
`define CSD_SRC_HOSC 2'h1
`define CSD_SRC_LOSC 2'h2
`define CSD_SRC_BUS 2'h3
`define CSD_TICK_EXT 3'h0
`define CSD_TICK_HOSC 3'h1
`define CSD_TICK_LOSC 3'h2
`define CSD_TICK_BUS 3'h3
`define CSD_SYS_EXT 3'h0
`define CSD_SYS_LOSC 3'h1
`define CSD_SYS_HOSC 3'h2
`define CSD_XTL_LOW 2'h2
`define CSD_RST_ZERO 32'h0000_0000
`define CSD_RST_SRCSEL 6'h02
`define CSD_RST_DIVCTL 6'h00
`define CSD_RST_PWRCTL 4'h0
`define CSD_RST_PERSEL 10'h000

// Allowed-source masks, bit i set means source code i is allowed
`define CSD_ALLOW_WDOG 4'hD
`define CSD_ALLOW_TMR 4'hF
`define CSD_ALLOW_UART 4'h3
`define CSD_ALLOW_ADC 4'hB

`endif

// ### csd_clock_select_divider.v
/*
 * Clock source selection, tick clock selection, per-peripheral clock
 * routing, power-down gating and power-of-two clock output divider.
 * Assumes an APB master on pclk and clock sources presented as levels
 * sampled on pclk, each well below half the pclk rate.
 */
// The implementer's own choices: the register offsets and the APB interface to the registers.
// Behaviour
// - System clock follows the 3-bit source field in select register bits 2..0.
// - Tick timer clock is processor clock or external tick clock, by control bit 2.
// - External tick clock chosen from four sources by select register bits 5..3.
// - Each peripheral only receives sources its clock table allows; others give low.
// - Power-down stops system clocks and sources, keeps low internal oscillator running.
// - Low crystal survives power-down only with keep bit 1 and crystal field 10.
// - Watchdog and timer clocks keep running in power-down on low internal oscillator.
// - Divider is sixteen chained halving stages, one stage picked by a mux.
// - Writing divider enable 1 with bypass clear starts the chained counter.
// - After enable cleared, counter runs until output low, then holds it low.
// - Bypass bit, with divider enable also set, routes the divider input clock straight to the output pin; bypass alone gives low.
`timescale 1ns/1ps
`include "csd_map.vh"

module csd_clock_select_divider #(
	parameter STAGES = 16
) (
	// APB slave
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	// Clock sources, sampled levels
	input wire high_speed_crystal,
	input wire low_speed_crystal,
	input wire high_internal_osc,
	input wire low_internal_osc,
	input wire bus_clock_in,
	input wire processor_clock_in,
	input wire divider_input_clock,
	// Selected clocks
	output reg system_clock_out,
	output reg tick_clock_out,
	output reg watchdog_clock_out,
	output reg timer0_clock_out,
	output reg timer1_clock_out,
	output reg uart_clock_out,
	output reg adc_clock_out,
	output reg bus_only_clock_out,
	output reg power_down_out,
	// Divider output pin
	output reg clock_output_pin
);

	// ****************************************
	// Source synchronisers
	// ****************************************
	localparam NSRC = 7;
	wire [NSRC-1:0] src_raw;
	wire [NSRC-1:0] src_sync;
	assign src_raw = {divider_input_clock, processor_clock_in, bus_clock_in,
		low_internal_osc, high_internal_osc, low_speed_crystal, high_speed_crystal};

	genvar gi;
	generate
		for (gi = 0; gi < NSRC; gi = gi + 1) begin : g_sync
			reg meta_reg;
			reg sync_reg;
			always @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					meta_reg <= 1'b0;
					sync_reg <= 1'b0;
				end else begin
					meta_reg <= src_raw[gi];
					sync_reg <= meta_reg;
				end
			end
			assign src_sync[gi] = sync_reg;
		end
	endgenerate

	// ****************************************
	// Source aliases
	// ****************************************

	wire hi_crystal_s = src_sync[0];
	wire lo_crystal_s = src_sync[1];
	wire hi_osc_s = src_sync[2];
	wire lo_osc_s = src_sync[3];
	wire bus_s = src_sync[4];
	wire cpu_s = src_sync[5];
	wire div_in_s = src_sync[6];

	// ****************************************
	// Registers
	// ****************************************
	reg [5:0] clock_source_select0_reg;
	reg [5:0] divider_output_control_reg;
	reg tick_timer_ctrl_status_reg;
	reg [3:0] power_control_reg;
	reg [9:0] periph_select_reg;

	wire [2:0] sys_sel = clock_source_select0_reg[`CSD_SYS_SEL_MSB:`CSD_SYS_SEL_LSB];
	wire [2:0] tick_clock_source_sel =
		clock_source_select0_reg[`CSD_TICK_SEL_MSB:`CSD_TICK_SEL_LSB];
	wire [3:0] divide_select = divider_output_control_reg[`CSD_DIV_SEL_MSB:`CSD_DIV_SEL_LSB];
	wire divider_enable = divider_output_control_reg[`CSD_DIV_EN_BIT];
	wire divider_bypass = divider_output_control_reg[`CSD_DIV_BYP_BIT];
	wire pd_req = power_control_reg[`CSD_PD_REQ_BIT];
	wire low_crystal_powerdown_keep = power_control_reg[`CSD_PD_KEEP_BIT];
	wire [1:0] crystal_enable_field = power_control_reg[`CSD_XTL_MSB:`CSD_XTL_LSB];

	// ****************************************
	// Register decode
	// ****************************************
	wire acc = psel && penable;
	wire wr = acc && pwrite;
	reg addr_ok;
	always @* begin
		case (paddr)
			`CSD_OFS_SRCSEL, `CSD_OFS_DIVCTL, `CSD_OFS_TICKCSR,
			`CSD_OFS_PWRCTL, `CSD_OFS_PERSEL, `CSD_OFS_STATUS: addr_ok = 1'b1;
			default: addr_ok = 1'b0;
		endcase
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clock_source_select0_reg <= `CSD_RST_SRCSEL;
			divider_output_control_reg <= `CSD_RST_DIVCTL;
			tick_timer_ctrl_status_reg <= 1'b0;
			power_control_reg <= `CSD_RST_PWRCTL;
			periph_select_reg <= `CSD_RST_PERSEL;
		end else if (wr) begin
			case (paddr)
				`CSD_OFS_SRCSEL: clock_source_select0_reg <= pwdata[5:0];
				`CSD_OFS_DIVCTL: divider_output_control_reg <= pwdata[5:0];
				`CSD_OFS_TICKCSR: tick_timer_ctrl_status_reg <= pwdata[`CSD_TICK_SRC_BIT];
				`CSD_OFS_PWRCTL: power_control_reg <= pwdata[3:0];
				`CSD_OFS_PERSEL: periph_select_reg <= pwdata[9:0];
				default: ;
			endcase
		end
	end

	// ****************************************
	// Power-down source gating
	// ****************************************
	// Only the low oscillator stays live in power-down; low crystal only when kept
	wire ext_is_low_crystal = (crystal_enable_field == `CSD_XTL_LOW);
	wire low_crystal_kept = low_crystal_powerdown_keep && ext_is_low_crystal;
	wire ext_raw = ext_is_low_crystal ? lo_crystal_s : hi_crystal_s;
	reg ext_g;
	reg hi_osc_g;
	reg lo_osc_g;
	reg bus_g;
	always @* begin
		ext_g = ext_raw;
		hi_osc_g = hi_osc_s;
		lo_osc_g = lo_osc_s;
		bus_g = bus_s;
		if (pd_req) begin
			ext_g = low_crystal_kept & lo_crystal_s;
			hi_osc_g = 1'b0;
			bus_g = 1'b0;
		end
	end
	wire [3:0] src_vec = {bus_g, lo_osc_g, hi_osc_g, ext_g};

	// ****************************************
	// Clock selection
	// ****************************************
	reg sys_next;
	always @* begin
		case (sys_sel)
			`CSD_SYS_EXT: sys_next = ext_raw;
			`CSD_SYS_LOSC: sys_next = lo_osc_s;
			`CSD_SYS_HOSC: sys_next = hi_osc_s;
			default: sys_next = hi_osc_s;
		endcase
	end

	// Reserved tick codes fall back to the external source
	reg tick_ext;
	reg tick_next;
	always @* begin
		case (tick_clock_source_sel)
			`CSD_TICK_EXT: tick_ext = src_vec[`CSD_SRC_EXT];
			`CSD_TICK_HOSC: tick_ext = src_vec[`CSD_SRC_HOSC];
			`CSD_TICK_LOSC: tick_ext = src_vec[`CSD_SRC_LOSC];
			`CSD_TICK_BUS: tick_ext = src_vec[`CSD_SRC_BUS];
			default: tick_ext = src_vec[`CSD_SRC_EXT];
		endcase
		if (tick_timer_ctrl_status_reg) begin
			tick_next = tick_ext;
		end else begin
			tick_next = cpu_s;
		end
	end

	// ****************************************
	// Peripheral source routing
	// ****************************************
	// One mask nibble per peripheral, in select-field order
	localparam NPER = 5;
	wire [4*NPER-1:0] allow_all = {`CSD_ALLOW_ADC, `CSD_ALLOW_UART, `CSD_ALLOW_TMR,
		`CSD_ALLOW_TMR, `CSD_ALLOW_WDOG};
	wire [NPER-1:0] periph_next;
	genvar pi;
	generate
		for (pi = 0; pi < NPER; pi = pi + 1) begin : g_periph
			wire [1:0] code = periph_select_reg[2*pi+1:2*pi];
			wire [3:0] allow = allow_all[4*pi+3:4*pi];
			// Disallowed codes give a constant low clock
			assign periph_next[pi] = allow[code] & src_vec[code];
		end
	endgenerate

	// ****************************************
	// Output registers
	// ****************************************

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			system_clock_out <= 1'b0;
			tick_clock_out <= 1'b0;
			watchdog_clock_out <= 1'b0;
			timer0_clock_out <= 1'b0;
			timer1_clock_out <= 1'b0;
			uart_clock_out <= 1'b0;
			adc_clock_out <= 1'b0;
			bus_only_clock_out <= 1'b0;
			power_down_out <= 1'b0;
		end else begin
			system_clock_out <= pd_req ? 1'b0 : sys_next;
			tick_clock_out <= pd_req ? 1'b0 : tick_next;
			// Low oscillator stays alive on watchdog and timer outputs in power-down via src_vec; uart and adc masks exclude it
			watchdog_clock_out <= periph_next[0];
			timer0_clock_out <= periph_next[1];
			timer1_clock_out <= periph_next[2];
			uart_clock_out <= periph_next[3];
			adc_clock_out <= periph_next[4];
			bus_only_clock_out <= bus_g;
			power_down_out <= pd_req;
		end
	end

	// ****************************************
	// Frequency divider
	// ****************************************
	reg div_in_d_reg;
	reg [STAGES-1:0] stage_reg;
	reg running_reg;
	wire div_rise = div_in_s && !div_in_d_reg;
	wire tap = stage_reg[divide_select];

	// ****************************************
	// Divider control
	// ****************************************
	reg run_next;
	reg pin_next;
	reg count_step;
	always @* begin
		// Keep counting after disable until the tap is low, avoiding a short pulse
		run_next = divider_enable || (running_reg && tap);
		count_step = run_next && div_rise && !divider_bypass;
		if (divider_bypass) begin
			pin_next = divider_enable & div_in_s;
		end else begin
			pin_next = run_next & tap;
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_in_d_reg <= 1'b0;
			stage_reg <= {STAGES{1'b0}};
			running_reg <= 1'b0;
			clock_output_pin <= 1'b0;
		end else begin
			div_in_d_reg <= div_in_s;
			running_reg <= run_next;
			// Chained halving stages form a ripple-equivalent binary counter
			if (count_step) begin
				stage_reg <= stage_reg + {{(STAGES-1){1'b0}}, 1'b1};
			end
			clock_output_pin <= pin_next;
		end
	end

	// ****************************************
	// Read path
	// ****************************************
	wire [31:0] status_word = {
		20'h00000,
		running_reg,
		clock_output_pin,
		pd_req,
		bus_only_clock_out,
		adc_clock_out,
		uart_clock_out,
		timer1_clock_out,
		timer0_clock_out,
		watchdog_clock_out,
		tick_clock_out,
		system_clock_out,
		low_crystal_kept
	};
	reg [31:0] rd_next;
	always @* begin
		case (paddr)
			`CSD_OFS_SRCSEL: rd_next = {26'h0000000, clock_source_select0_reg};
			`CSD_OFS_DIVCTL: rd_next = {26'h0000000, divider_output_control_reg};
			`CSD_OFS_TICKCSR: rd_next = {29'h00000000, tick_timer_ctrl_status_reg, 2'h0};
			`CSD_OFS_PWRCTL: rd_next = {28'h0000000, power_control_reg};
			`CSD_OFS_PERSEL: rd_next = {22'h000000, periph_select_reg};
			`CSD_OFS_STATUS: rd_next = status_word;
			default: rd_next = 32'h0000_0000;
		endcase
	end

	// ****************************************
	// APB response
	// ****************************************
	// Zero-wait slave: pready and data are registered from the setup cycle, valid in the access cycle
	wire setup = psel && !penable;
	reg [31:0] prdata_next;
	always @* begin
		prdata_next = `CSD_RST_ZERO;
		if (setup && !pwrite) begin
			prdata_next = rd_next;
		end
	end
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= `CSD_RST_ZERO;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= setup;
			pslverr <= setup && !addr_ok;
			prdata <= prdata_next;
		end
	end

endmodule

// ### csd_pin_monitor.sv
/* Receiver of the divided clock pin: measures its period and low time.
   Assumes the pin is a level sampled on pclk. */
`timescale 1ns/1ps
module csd_pin_monitor (
	// Clock and reset
	pclk,
	presetn,
	// Pin
	clock_output_pin,
	// Measurements
	period,
	low_run
);
	input wire pclk;
	input wire presetn;
	input wire clock_output_pin;
	output reg [19:0] period;
	output reg [19:0] low_run;
	reg last_reg;
	reg [19:0] cnt_reg;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			last_reg <= 1'b0;
			cnt_reg <= 20'h0;
			period <= 20'h0;
			low_run <= 20'h0;
		end else begin
			last_reg <= clock_output_pin;
			low_run <= clock_output_pin ? 20'h0 : low_run + 20'h1;
			cnt_reg <= (clock_output_pin && !last_reg) ? 20'h1 : cnt_reg + 20'h1;
			if (clock_output_pin && !last_reg)
				period <= cnt_reg;
		end
	end
endmodule

// ### csd_checker.sv
/* Assertions on bus handshake, power-down gating and the divider pin.
   Assumes it is bound to the clock select and divider top module. */
`timescale 1ns/1ps
module csd_checker (
	// Bus
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] prdata,
	input wire pready,
	input wire pslverr,
	// Clocks
	input wire bus_clock_in,
	input wire system_clock_out,
	input wire bus_only_clock_out,
	input wire power_down_out,
	input wire clock_output_pin
);
	reg [2:0] up_reg;
	// Cycles since reset release, so delayed samples never reach into reset
	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			up_reg <= 3'h0;
		else if (up_reg != 3'h7)
			up_reg <= up_reg + 3'h1;
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	chk_ready_after_setup: assert property (psel && !penable |=> pready)
		else $error("no pready after setup");
	chk_ready_single: assert property (pready |=> !pready)
		else $error("pready held");
	chk_err_unmapped: assert property (psel && !penable && paddr > 12'h014 |=> pslverr)
		else $error("no pslverr");
	chk_err_with_ready: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	chk_rdata_idle: assert property (!pready |-> prdata == 32'h0)
		else $error("prdata outside access");
	chk_pd_by_write: assert property ($rose(power_down_out) |-> $past(psel && penable && pwrite, 2))
		else $error("power down without write");
	chk_pd_gates_sys: assert property (power_down_out [*4] |-> !system_clock_out && !bus_only_clock_out)
		else $error("clock alive in power down");
	chk_bus_follow: assert property ((up_reg == 3'h7 && !power_down_out) [*5] |-> bus_only_clock_out == $past(bus_clock_in, 3))
		else $error("bus clock not followed");
	chk_pin_low_boot: assert property (up_reg < 3'h4 |-> !clock_output_pin)
		else $error("pin high after reset");
endmodule
bind csd_clock_select_divider csd_checker csd_checker_i (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .bus_clock_in(bus_clock_in),
	.system_clock_out(system_clock_out), .bus_only_clock_out(bus_only_clock_out),
	.power_down_out(power_down_out), .clock_output_pin(clock_output_pin));

// ### csd_clock_select_divider_bench.sv
/* Register-level bench of the clock select and divider block.
   Assumes sources no faster than a quarter of pclk and zero-wait APB. */
`timescale 1ns/1ps
module csd_clock_select_divider_bench;
	reg pclk, presetn, psel, penable, pwrite;
	reg [11:0] paddr;
	reg [31:0] pwdata, q;
	reg [7:0] cyc, h0, h1, h2;
	reg e, last;
	wire [31:0] prdata;
	wire pready, pslverr;
	wire [8:0] outs;
	wire [19:0] period, low_run;
	// Index: 0 none,1 hi crystal,2 lo crystal,3 hi osc,4 lo osc,5 bus,6 cpu,7 divider input
	wire [7:0] src = {cyc[1], cyc[3] ^ cyc[2], cyc[4], cyc[5], cyc[2], cyc[6], cyc[3], 1'b0};
	integer fail_count = 0, checks = 0, i, n;
	integer smap[3] = '{1, 4, 3};
	integer tmap[4] = '{1, 3, 4, 5};
	csd_clock_select_divider csd_clock_select_divider_i (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .high_speed_crystal(src[1]),
		.low_speed_crystal(src[2]), .high_internal_osc(src[3]), .low_internal_osc(src[4]),
		.bus_clock_in(src[5]), .processor_clock_in(src[6]), .divider_input_clock(src[7]),
		.system_clock_out(outs[0]), .tick_clock_out(outs[1]), .watchdog_clock_out(outs[2]),
		.timer0_clock_out(outs[3]), .timer1_clock_out(outs[4]), .uart_clock_out(outs[5]),
		.adc_clock_out(outs[6]), .bus_only_clock_out(outs[7]), .power_down_out(),
		.clock_output_pin(outs[8]));
	csd_pin_monitor csd_pin_monitor_i (.pclk(pclk), .presetn(presetn),
		.clock_output_pin(outs[8]), .period(period), .low_run(low_run));
	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end
	// Sources sampled two edges back line up with the selected outputs
	always @(posedge pclk) begin
		cyc <= cyc + 8'h01;
		h0 <= src;
		h1 <= h0;
		h2 <= h1;
	end
	task complete_run;
		begin
			if (fail_count == 0 && checks > 0)
				$display("[ PASS ]");
			else
				$display("[ FAIL ]");
			$finish;
		end
	endtask
	task cmp(input string nm, input [31:0] x, input [31:0] g);
		begin
			checks = checks + 1;
			if (g !== x) begin
				fail_count = fail_count + 1;
				$display("[FAIL] %0s expected %h seen %h", nm, x, g);
			end
		end
	endtask
	task apb(input [11:0] a, input w, input [31:0] d);
		integer k;
		begin
			k = 0;
			@(posedge pclk);
			psel <= 1'b1;
			paddr <= a;
			pwrite <= w;
			pwdata <= d;
			@(posedge pclk);
			penable <= 1'b1;
			@(posedge pclk);
			while (pready !== 1'b1) begin
				@(posedge pclk);
				k = k + 1;
			end
			q = prdata;
			e = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask
	task wr(input [11:0] a, input [31:0] d);
		apb(a, 1'b1, d);
	endtask
	task rdc(input string nm, input [11:0] a, input [31:0] x);
		begin
			apb(a, 1'b0, 32'h0);
			cmp(nm, x, q);
		end
	endtask
	task watch(input string nm, input integer oi, input integer si);
		integer k;
		begin
			n = 0;
			repeat (4) @(posedge pclk);
			for (k = 0; k < 150; k = k + 1) begin
				@(negedge pclk);
				if (outs[oi] !== h2[si])
					n = n + 1;
			end
			cmp(nm, 0, n);
		end
	endtask
	task pin_period(input [31:0] x);
		integer r, k;
		begin
			r = 0;
			for (k = 0; k < 3000 && r < 3; k = k + 1) begin
				@(negedge pclk);
				if (outs[8] === 1'b1 && last === 1'b0)
					r = r + 1;
				last = outs[8];
			end
			repeat (2) @(negedge pclk);
			cmp("pin_period", x, period);
		end
	endtask
	initial begin
		#1000000;
		fail_count = fail_count + 1;
		complete_run;
	end
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata, cyc, last} = 0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		rdc("srcsel", 12'h000, 32'h2);
		rdc("divctl", 12'h004, 32'h0);
		rdc("tickcsr", 12'h008, 32'h0);
		rdc("pwrctl", 12'h00C, 32'h0);
		rdc("persel", 12'h010, 32'h0);
		apb(12'h018, 1'b0, 32'h0);
		cmp("unmapped", 32'h1, {q[30:0], e});
		for (i = 0; i < 3; i = i + 1) begin
			wr(12'h000, i);
			watch("sys_clock", 0, smap[i]);
		end
		wr(12'h008, 32'h4);
		for (i = 0; i < 4; i = i + 1) begin
			wr(12'h000, (i << 3) | 2);
			watch("tick_clock", 1, tmap[i]);
		end
		wr(12'h008, 32'h0);
		watch("tick_cpu", 1, 6);
		wr(12'h010, 32'h3B9);
		watch("wdog_hosc", 2, 0);
		watch("tmr0_losc", 3, 4);
		watch("uart_losc", 5, 0);
		watch("adc_bus", 6, 5);
		wr(12'h010, 32'h246);
		watch("tmr1_ext", 4, 1);
		watch("uart_hosc", 5, 3);
		watch("adc_losc", 6, 0);
		wr(12'h00C, 32'h1);
		watch("pd_sys", 0, 0);
		watch("pd_wdog", 2, 4);
		watch("pd_tmr0", 3, 0);
		wr(12'h00C, 32'hB);
		watch("pd_lcrys", 4, 2);
		wr(12'h00C, 32'h7);
		watch("pd_no_lcrys", 4, 0);
		wr(12'h00C, 32'h0);
		for (i = 0; i < 6; i = i + 2) begin
			wr(12'h004, 32'h10 | i);
			pin_period(8 << i);
		end
		while (outs[8] !== 1'b1)
			@(negedge pclk);
		wr(12'h004, 32'h4);
		@(negedge pclk);
		cmp("stop_hold", 1, outs[8]);
		repeat (300) @(posedge pclk);
		cmp("stop_low", 1, low_run > 200);
		wr(12'h004, 32'h30);
		watch("bypass", 8, 7);
		wr(12'h004, 32'h20);
		watch("bypass_off", 8, 0);
		complete_run;
	end
endmodule
